//--- core/mpio_pkg.sv
// constants, register map and state types of the multi-port i/o block
`default_nettype none
package mpio_pkg;
  localparam int ADDR_W = 16;
  localparam int IDX_W = 13;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_P1_LATCH = 13'h0001;
  localparam logic [IDX_W-1:0] IDX_P2_LATCH = 13'h0002;
  localparam logic [IDX_W-1:0] IDX_P3_OUTPUT_LATCH = 13'h0003;
  localparam logic [IDX_W-1:0] IDX_P4_LATCH = 13'h0004;
  localparam logic [IDX_W-1:0] IDX_P6_LATCH = 13'h0006;
  localparam logic [IDX_W-1:0] IDX_P3_DRAIN_SELECT = 13'h1F83;
  localparam logic [IDX_W-1:0] IDX_P4_DRAIN_SELECT = 13'h1F84;
  localparam logic [IDX_W-1:0] IDX_P1_DIRECTION = 13'h1F88;
  localparam logic [IDX_W-1:0] IDX_P3_DIRECTION = 13'h1F89;
  localparam logic [IDX_W-1:0] IDX_P4_DIRECTION = 13'h1F8A;
  localparam logic [IDX_W-1:0] IDX_P6_DIRECTION = 13'h1F8B;
  localparam logic [IDX_W-1:0] IDX_ANALOG_CTRL = 13'h1F8C;
  // address bit that selects the latch view of a read-modify-write read
  localparam int RMW_VIEW_BIT = 15;
  // analog control fields
  localparam int AIN_DIS_BIT = 4;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 3;
  // positions of each port inside the 33-bit pin vector
  localparam int PIN_W = 33;
  localparam int P1_LSB = 0;
  localparam int P2_LSB = 6;
  localparam int P3_LSB = 9;
  localparam int P4_LSB = 17;
  localparam int P6_LSB = 25;
  // reset values and response codes
  localparam logic [5:0] P1_RST = 6'h00;
  localparam logic [2:0] P2_LATCH_RST = 3'h7;
  localparam logic [7:0] P8_RST = 8'h00;
  localparam logic AIN_DIS_RST = 1'b1;
  localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_RD_S1, ST_RD_S2, ST_WR_S1, ST_WR_S2, ST_WR_RESP} mpio_phase_t;

  typedef struct packed {
    logic [5:0] port1_latch;
    logic [5:0] port1_direction;
    logic [2:0] port2_latch;
    logic [7:0] port3_output_latch;
    logic [7:0] port3_direction;
    logic [7:0] port3_drain_select;
    logic [7:0] port4_latch;
    logic [7:0] port4_direction;
    logic [7:0] port4_drain_select;
    logic [7:0] port6_latch;
    logic [7:0] port6_direction;
    logic analog_input_disable;
    logic [CHAN_W-1:0] analog_channel_select;
  } mpio_regs_t;

  typedef struct packed {
    logic ok;
    logic [7:0] data;
  } mpio_rd_t;

  typedef struct packed {
    mpio_phase_t phase;
    mpio_regs_t regs;
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic [PIN_W-1:0] sync3;
    logic [PIN_W-1:0] pins;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wbyte;
    logic [ADDR_W-1:0] araddr;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
    logic p20_fall;
    logic conv_start;
  } mpio_state_t;
endpackage
`default_nettype wire

//--- core/mpio_ports.sv
// five general-purpose i/o ports behind an axi4-lite register slave
`default_nettype none
module mpio_ports
  import mpio_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_s_awaddr,
  input wire logic i_s_awvalid,
  output logic o_s_awready,
  input wire logic [31:0] i_s_wdata,
  input wire logic [3:0] i_s_wstrb,
  input wire logic i_s_wvalid,
  output logic o_s_wready,
  output logic [1:0] o_s_bresp,
  output logic o_s_bvalid,
  input wire logic i_s_bready,
  input wire logic [ADDR_W-1:0] i_s_araddr,
  input wire logic i_s_arvalid,
  output logic o_s_arready,
  output logic [31:0] o_s_rdata,
  output logic [1:0] o_s_rresp,
  output logic o_s_rvalid,
  input wire logic i_s_rready,
  input wire logic [5:0] i_p1_in,
  output logic [5:0] o_p1_out,
  output logic [5:0] o_p1_oe,
  input wire logic [2:0] i_p2_in,
  output logic [2:0] o_p2_out,
  output logic [2:0] o_p2_oe,
  input wire logic [7:0] i_p3_in,
  output logic [7:0] o_p3_out,
  output logic [7:0] o_p3_oe,
  input wire logic [7:0] i_p4_in,
  output logic [7:0] o_p4_out,
  output logic [7:0] o_p4_oe,
  input wire logic [7:0] i_p6_in,
  output logic [7:0] o_p6_out,
  output logic [7:0] o_p6_oe,
  input wire logic i_stop_mode,
  input wire logic i_stop_output_hold,
  output logic o_port2_pin0_fall,
  output logic o_analog_input_disable,
  output logic [CHAN_W-1:0] o_analog_channel_select,
  output logic o_conversion_start
);

  mpio_state_t st;
  mpio_state_t next_st;
  logic [PIN_W-1:0] pin_raw;
  logic ar_fire;
  logic aw_fire;
  logic w_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [IDX_W-1:0] wr_idx;
  mpio_rd_t rd;
  logic [7:0] p3_oe_core;
  logic [7:0] p4_oe_core;

  assign pin_raw = {i_p6_in, i_p4_in, i_p3_in, i_p2_in, i_p1_in};

  // read mux; the view bit marks a read-modify-write read
  function automatic mpio_rd_t read_reg(input logic [IDX_W-1:0] idx, input logic view,
                                        input mpio_regs_t r, input logic [PIN_W-1:0] p);
    mpio_rd_t res;
    res.ok = 1'b1;
    res.data = 8'h00;
    unique case (idx)
      // undefined upper bits read as zero here
      IDX_P1_LATCH: res.data = {2'h0, view ? r.port1_latch : p[P1_LSB +: 6]};
      // unimplemented upper bits of port two read as zero
      IDX_P2_LATCH: res.data = {5'h00, view ? r.port2_latch : p[P2_LSB +: 3]};
      IDX_P3_OUTPUT_LATCH: res.data = view ? r.port3_output_latch : p[P3_LSB +: 8];
      IDX_P4_LATCH: res.data = view ? r.port4_latch : p[P4_LSB +: 8];
      // port six always reads pins, masked by the latch
      IDX_P6_LATCH: res.data = p[P6_LSB +: 8] & r.port6_latch;
      IDX_P1_DIRECTION: res.data = {2'h0, r.port1_direction};
      IDX_P3_DIRECTION: res.data = r.port3_direction;
      IDX_P3_DRAIN_SELECT: res.data = r.port3_drain_select;
      IDX_P4_DIRECTION: res.data = r.port4_direction;
      IDX_P4_DRAIN_SELECT: res.data = r.port4_drain_select;
      IDX_P6_DIRECTION: res.data = r.port6_direction;
      IDX_ANALOG_CTRL: begin
        res.data[AIN_DIS_BIT] = r.analog_input_disable;
        res.data[CHAN_LSB +: CHAN_W] = r.analog_channel_select;
      end
      default: res.ok = 1'b0;
    endcase
    return res;
  endfunction

  // write address bits wait here until both halves arrive
  assign wr_addr = st.awaddr;
  assign wr_idx = wr_addr[IDX_W+1:2];

  // write is favoured; a read waits while any write half is pending
  assign o_s_awready = (st.phase == ST_IDLE) && !st.aw_got;
  assign o_s_wready = (st.phase == ST_IDLE) && !st.w_got;
  assign o_s_arready = (st.phase == ST_IDLE) && !st.aw_got && !st.w_got && !i_s_awvalid && !i_s_wvalid;
  assign aw_fire = i_s_awvalid && o_s_awready;
  assign w_fire = i_s_wvalid && o_s_wready;
  assign ar_fire = i_s_arvalid && o_s_arready;
  assign o_s_rvalid = (st.phase == ST_RD_S2);
  assign o_s_bvalid = (st.phase == ST_WR_RESP);
  assign o_s_rdata = st.rdata;
  assign o_s_rresp = st.rresp;
  assign o_s_bresp = st.bresp;
  assign rd = read_reg(st.araddr[IDX_W+1:2], st.araddr[RMW_VIEW_BIT], st.regs, st.pins);

  always_comb begin
    next_st = st;
    next_st.p20_fall = 1'b0;
    next_st.conv_start = 1'b0;
    // three-stage sync; a bit changes once stages two and three agree
    next_st.sync1 = pin_raw;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    for (int i = 0; i < PIN_W; i++) begin
      if (st.sync2[i] == st.sync3[i]) begin
        next_st.pins[i] = st.sync3[i];
      end
    end
    unique case (st.phase)
      ST_IDLE: begin
        if (aw_fire) begin
          next_st.aw_got = 1'b1;
          next_st.awaddr = i_s_awaddr;
        end
        if (w_fire) begin
          next_st.w_got = 1'b1;
          next_st.wdata = i_s_wdata[7:0];
          next_st.wbyte = i_s_wstrb[0];
        end
        if ((st.aw_got || aw_fire) && (st.w_got || w_fire)) begin
          next_st.phase = ST_WR_S1;
        end else if (ar_fire) begin
          next_st.araddr = i_s_araddr;
          next_st.phase = ST_RD_S1;
        end
      end
      ST_RD_S1: begin
        // pins are captured in this first state
        next_st.rdata = {24'h000000, rd.data};
        next_st.rresp = rd.ok ? RESP_OKAY : RESP_SLVERR;
        next_st.phase = ST_RD_S2;
      end
      ST_RD_S2: begin
        if (i_s_rready) begin
          next_st.phase = ST_IDLE;
        end
      end
      ST_WR_S1: begin
        next_st.bresp = RESP_OKAY;
        next_st.phase = ST_WR_S2;
      end
      ST_WR_S2: begin
        // latches take the data in the second state
        next_st.phase = ST_WR_RESP;
        next_st.aw_got = 1'b0;
        next_st.w_got = 1'b0;
        if (st.wbyte) begin
          case (wr_idx)
            IDX_P1_LATCH: next_st.regs.port1_latch = st.wdata[5:0];
            IDX_P2_LATCH: next_st.regs.port2_latch = st.wdata[2:0];
            IDX_P3_OUTPUT_LATCH: next_st.regs.port3_output_latch = st.wdata;
            IDX_P4_LATCH: next_st.regs.port4_latch = st.wdata;
            // all eight bits are overwritten, input bits included
            IDX_P6_LATCH: next_st.regs.port6_latch = st.wdata;
            IDX_P1_DIRECTION: next_st.regs.port1_direction = st.wdata[5:0];
            IDX_P3_DIRECTION: next_st.regs.port3_direction = st.wdata;
            IDX_P3_DRAIN_SELECT: next_st.regs.port3_drain_select = st.wdata;
            IDX_P4_DIRECTION: next_st.regs.port4_direction = st.wdata;
            IDX_P4_DRAIN_SELECT: next_st.regs.port4_drain_select = st.wdata;
            IDX_P6_DIRECTION: next_st.regs.port6_direction = st.wdata;
            IDX_ANALOG_CTRL: begin
              next_st.regs.analog_input_disable = st.wdata[AIN_DIS_BIT];
              next_st.regs.analog_channel_select = st.wdata[CHAN_LSB +: CHAN_W];
              // clearing the disable bit kicks off a conversion
              next_st.conv_start = st.regs.analog_input_disable && !st.wdata[AIN_DIS_BIT];
            end
            default: next_st.bresp = RESP_SLVERR;
          endcase
        end
        // a falling driven level on pin zero flags the interrupt latch
        next_st.p20_fall = st.regs.port2_latch[0] && !next_st.regs.port2_latch[0];
      end
      ST_WR_RESP: begin
        if (i_s_bready) begin
          next_st.phase = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      st <= '0;
      st.phase <= ST_IDLE;
      st.regs.port1_latch <= P1_RST;
      st.regs.port1_direction <= P1_RST;
      st.regs.port2_latch <= P2_LATCH_RST;
      st.regs.port3_output_latch <= P8_RST;
      st.regs.port3_direction <= P8_RST;
      st.regs.port3_drain_select <= P8_RST;
      st.regs.port4_latch <= P8_RST;
      st.regs.port4_direction <= P8_RST;
      st.regs.port4_drain_select <= P8_RST;
      st.regs.port6_latch <= P8_RST;
      st.regs.port6_direction <= P8_RST;
      st.regs.analog_input_disable <= AIN_DIS_RST;
      st.regs.analog_channel_select <= CHAN_RST;
    end else begin
      st <= next_st;
    end
  end

  // open-drain pins only sink; push-pull pins follow direction
  assign p3_oe_core = st.regs.port3_direction & ~(st.regs.port3_drain_select & st.regs.port3_output_latch);
  assign p4_oe_core = st.regs.port4_direction & ~(st.regs.port4_drain_select & st.regs.port4_latch);

  // stop gates all drivers unless held; in stop pin zero of port two floats even when held
  always_comb begin
    o_p1_out = st.regs.port1_latch;
    o_p1_oe = st.regs.port1_direction;
    // port two has no direction register: a zero latch sinks, a one releases
    o_p2_out = 3'h0;
    o_p2_oe = ~st.regs.port2_latch;
    o_p3_out = st.regs.port3_output_latch & ~st.regs.port3_drain_select;
    o_p3_oe = p3_oe_core;
    o_p4_out = st.regs.port4_latch & ~st.regs.port4_drain_select;
    o_p4_oe = p4_oe_core;
    o_p6_out = st.regs.port6_latch;
    o_p6_oe = st.regs.port6_direction;
    if (i_stop_mode) begin
      if (!i_stop_output_hold) begin
        o_p1_oe = 6'h00;
        o_p2_oe = 3'h0;
        o_p3_oe = 8'h00;
        o_p4_oe = 8'h00;
        o_p6_oe = 8'h00;
      end
      o_p2_oe[0] = 1'b0;
    end
  end

  assign o_port2_pin0_fall = st.p20_fall;
  assign o_analog_input_disable = st.regs.analog_input_disable;
  assign o_analog_channel_select = st.regs.analog_channel_select;
  assign o_conversion_start = st.conv_start;

  sequence s_read_tail;
    (st.phase == ST_RD_S1) ##1 o_s_rvalid;
  endsequence

  sequence s_write_tail;
    (st.phase == ST_WR_S2) ##1 o_s_bvalid;
  endsequence

  chk_read_two_states: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    ar_fire |=> s_read_tail)
    else $error("read did not answer after two states");

  chk_write_two_states: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (st.phase == ST_WR_S1) |=> s_write_tail)
    else $error("write did not commit in second state");

  chk_p1_latch_write: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (st.phase == ST_WR_S2 && st.wbyte && wr_idx == IDX_P1_LATCH) |=> (o_p1_out == st.wdata[5:0]))
    else $error("port one latch did not take written data");

  chk_reset_values: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $rose(i_nrst) |-> (o_p1_oe == 6'h00 && o_p1_out == 6'h00 && st.regs.port2_latch == 3'h7
                       && o_analog_input_disable && o_p6_oe == 8'h00))
    else $error("port reset values wrong");

  chk_stop_p20_float: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_stop_mode |-> !o_p2_oe[0])
    else $error("port two pin zero driven in stop");

  chk_p20_fall_flag: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $fell(st.regs.port2_latch[0]) |-> o_port2_pin0_fall ##1 !o_port2_pin0_fall)
    else $error("pin zero fall not flagged for one cycle");

  chk_open_drain_release: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (st.regs.port3_drain_select[0] && st.regs.port3_output_latch[0]) |-> !o_p3_oe[0])
    else $error("open-drain port three bit drives high");

  chk_rmw_latch_view: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (o_s_rvalid && st.araddr[RMW_VIEW_BIT] && st.araddr[IDX_W+1:2] == IDX_P3_OUTPUT_LATCH)
      |-> (o_s_rdata[7:0] == st.regs.port3_output_latch))
    else $error("read-modify-write read not from latch");

  chk_p6_zero_latch: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (o_s_rvalid && st.araddr[IDX_W+1:2] == IDX_P6_LATCH) |-> ((o_s_rdata[7:0] & ~st.regs.port6_latch) == 8'h00))
    else $error("port six bit with zero latch read nonzero");

  chk_conv_start: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $fell(o_analog_input_disable) |-> o_conversion_start)
    else $error("clearing analog disable did not start conversion");

endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking testbench of the multi-port i/o block
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("Error at %0t ns: got %h expected %h", $time, got, exp); end end
module tb
  import mpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, stop, hold;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, fall, dis, conv;
  logic [1:0] bresp, rresp;
  logic [5:0] p1_in, p1_out, p1_oe;
  logic [2:0] p2_in, p2_out, p2_oe, chan;
  logic [7:0] p3_in, p3_out, p3_oe, p4_in, p4_out, p4_oe, p6_in, p6_out, p6_oe;
  logic fall_seen = 1'h0;
  logic conv_seen = 1'h0;
  int n_fail, compares;

  mpio_ports mpio_ports_i (.i_core_clk(clk), .i_nrst(nrst), .i_s_awaddr(awaddr), .i_s_awvalid(awvalid),
    .o_s_awready(awready), .i_s_wdata(wdata), .i_s_wstrb(wstrb), .i_s_wvalid(wvalid), .o_s_wready(wready),
    .o_s_bresp(bresp), .o_s_bvalid(bvalid), .i_s_bready(bready), .i_s_araddr(araddr), .i_s_arvalid(arvalid),
    .o_s_arready(arready), .o_s_rdata(rdata), .o_s_rresp(rresp), .o_s_rvalid(rvalid), .i_s_rready(rready),
    .i_p1_in(p1_in), .o_p1_out(p1_out), .o_p1_oe(p1_oe), .i_p2_in(p2_in), .o_p2_out(p2_out), .o_p2_oe(p2_oe),
    .i_p3_in(p3_in), .o_p3_out(p3_out), .o_p3_oe(p3_oe), .i_p4_in(p4_in), .o_p4_out(p4_out), .o_p4_oe(p4_oe),
    .i_p6_in(p6_in), .o_p6_out(p6_out), .o_p6_oe(p6_oe), .i_stop_mode(stop), .i_stop_output_hold(hold),
    .o_port2_pin0_fall(fall), .o_analog_input_disable(dis), .o_analog_channel_select(chan),
    .o_conversion_start(conv));

  always #20 clk = ~clk;

  // one-cycle pulses are caught on the falling edge, clear of the edge that launches them
  always @(negedge clk) begin
    if (fall === 1'h1) fall_seen <= 1'h1;
    if (conv === 1'h1) conv_seen <= 1'h1;
  end

  function automatic logic [15:0] ba(input logic [IDX_W-1:0] idx, input logic rmw);
    return {rmw, idx, 2'h0};
  endfunction

  task automatic test_done();
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // each task starts on a fresh edge so no signal is assigned twice in one step
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [3:0] st,
                    input logic [1:0] exp_r);
    logic [1:0] r;
    @(posedge clk);
    awaddr <= ba(idx, 1'h0);
    wdata <= {24'h000000, d};
    wstrb <= st;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(negedge clk); while (awready !== 1'h1 || wready !== 1'h1);
    @(posedge clk);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(negedge clk); while (bvalid !== 1'h1);
    r = bresp;
    @(posedge clk);
    bready <= 1'h0;
    `CHK(r, exp_r)
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic rmw, input logic [7:0] exp_d,
                    input logic [1:0] exp_r);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= ba(idx, rmw);
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge clk); while (arready !== 1'h1);
    @(posedge clk);
    arvalid <= 1'h0;
    do @(negedge clk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'h0;
    `CHK(d, {24'h000000, exp_d})
    `CHK(r, exp_r)
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end

  initial begin
    clk = 1'h0; nrst = 1'h0; awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0; arvalid = 1'h0;
    rready = 1'h0; awaddr = 16'h0000; araddr = 16'h0000; wdata = 32'h00000000; wstrb = 4'h0;
    stop = 1'h0; hold = 1'h0; n_fail = 0; compares = 0;
    p1_in = 6'h2A; p2_in = 3'h5; p3_in = 8'hA5; p4_in = 8'h3C; p6_in = 8'hFF;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    @(negedge clk);
    `CHK({p1_oe, p2_oe, p3_oe, p4_oe, p6_oe}, 33'h000000000)
    `CHK(dis, 1'h1)
    rd(IDX_P1_LATCH, 1'h1, 8'h00, RESP_OKAY);
    rd(IDX_P1_DIRECTION, 1'h0, 8'h00, RESP_OKAY);
    rd(IDX_P2_LATCH, 1'h1, 8'h07, RESP_OKAY);
    rd(IDX_P3_OUTPUT_LATCH, 1'h1, 8'h00, RESP_OKAY);
    rd(IDX_P3_DIRECTION, 1'h0, 8'h00, RESP_OKAY);
    rd(IDX_P3_DRAIN_SELECT, 1'h0, 8'h00, RESP_OKAY);
    rd(IDX_P4_LATCH, 1'h1, 8'h00, RESP_OKAY);
    rd(IDX_P4_DIRECTION, 1'h0, 8'h00, RESP_OKAY);
    rd(IDX_P4_DRAIN_SELECT, 1'h0, 8'h00, RESP_OKAY);
    rd(IDX_P6_DIRECTION, 1'h0, 8'h00, RESP_OKAY);
    rd(IDX_ANALOG_CTRL, 1'h0, 8'h10, RESP_OKAY);
    rd(IDX_P6_LATCH, 1'h0, 8'h00, RESP_OKAY);
    // plain reads see the pins; upper unused bits come back zero by choice
    rd(IDX_P1_LATCH, 1'h0, 8'h2A, RESP_OKAY);
    rd(IDX_P2_LATCH, 1'h0, 8'h05, RESP_OKAY);
    rd(IDX_P3_OUTPUT_LATCH, 1'h0, 8'hA5, RESP_OKAY);
    // port three: latch, direction, then open-drain on every bit
    wr(IDX_P3_OUTPUT_LATCH, 8'h5A, 4'hF, RESP_OKAY);
    wr(IDX_P3_DIRECTION, 8'hF0, 4'hF, RESP_OKAY);
    `CHK(p3_out, 8'h5A)
    `CHK(p3_oe, 8'hF0)
    rd(IDX_P3_OUTPUT_LATCH, 1'h1, 8'h5A, RESP_OKAY);
    rd(IDX_P3_OUTPUT_LATCH, 1'h0, 8'hA5, RESP_OKAY);
    wr(IDX_P3_DRAIN_SELECT, 8'hFF, 4'hF, RESP_OKAY);
    `CHK(p3_oe, 8'hA0)
    `CHK(p3_out, 8'h00)
    rd(IDX_P3_OUTPUT_LATCH, 1'h1, 8'h5A, RESP_OKAY);
    // a write with its byte lane off must leave the latch alone
    wr(IDX_P3_OUTPUT_LATCH, 8'hFF, 4'h0, RESP_OKAY);
    rd(IDX_P3_OUTPUT_LATCH, 1'h1, 8'h5A, RESP_OKAY);
    // port four mixes push-pull high nibble with open-drain low nibble
    wr(IDX_P4_LATCH, 8'h3C, 4'hF, RESP_OKAY);
    wr(IDX_P4_DIRECTION, 8'hFF, 4'hF, RESP_OKAY);
    wr(IDX_P4_DRAIN_SELECT, 8'h0F, 4'hF, RESP_OKAY);
    `CHK(p4_out, 8'h30)
    `CHK(p4_oe, 8'hF3)
    p4_in <= 8'hC3;
    repeat (6) @(posedge clk);
    rd(IDX_P4_LATCH, 1'h0, 8'hC3, RESP_OKAY);
    rd(IDX_P4_LATCH, 1'h1, 8'h3C, RESP_OKAY);
    // port one
    wr(IDX_P1_LATCH, 8'h15, 4'hF, RESP_OKAY);
    wr(IDX_P1_DIRECTION, 8'h3F, 4'hF, RESP_OKAY);
    `CHK(p1_out, 6'h15)
    `CHK(p1_oe, 6'h3F)
    rd(IDX_P1_LATCH, 1'h1, 8'h15, RESP_OKAY);
    rd(IDX_P1_LATCH, 1'h0, 8'h2A, RESP_OKAY);
    // port two pin zero driven low from its reset high
    `CHK(fall_seen, 1'h0)
    wr(IDX_P2_LATCH, 8'h06, 4'hF, RESP_OKAY);
    `CHK(fall_seen, 1'h1)
    `CHK(p2_oe, 3'h1)
    `CHK(p2_out, 3'h0)
    rd(IDX_P2_LATCH, 1'h1, 8'h06, RESP_OKAY);
    rd(IDX_P2_LATCH, 1'h0, 8'h05, RESP_OKAY);
    // stop mode with and without output hold
    @(posedge clk);
    stop <= 1'h1;
    hold <= 1'h1;
    @(negedge clk);
    `CHK(p2_oe, 3'h0)
    `CHK(p3_oe, 8'hA0)
    @(posedge clk);
    hold <= 1'h0;
    @(negedge clk);
    `CHK(p3_oe, 8'h00)
    @(posedge clk);
    stop <= 1'h0;
    // port three latch set to one before the pins hand over to motor outputs
    wr(IDX_P3_OUTPUT_LATCH, 8'hFF, 4'hF, RESP_OKAY);
    `CHK(p3_oe, 8'h00)
    `CHK(p3_out, 8'h00)
    rd(IDX_P3_OUTPUT_LATCH, 1'h1, 8'hFF, RESP_OKAY);
    wr(IDX_P3_DRAIN_SELECT, 8'h00, 4'hF, RESP_OKAY);
    `CHK(p3_out, 8'hFF)
    `CHK(p3_oe, 8'hF0)
    // port six: pins all high, latch masks the read in both views
    wr(IDX_P6_LATCH, 8'h0F, 4'hF, RESP_OKAY);
    rd(IDX_P6_LATCH, 1'h0, 8'h0F, RESP_OKAY);
    rd(IDX_P6_LATCH, 1'h1, 8'h0F, RESP_OKAY);
    wr(IDX_P6_DIRECTION, 8'hF0, 4'hF, RESP_OKAY);
    `CHK(p6_out, 8'h0F)
    `CHK(p6_oe, 8'hF0)
    // clearing the analog disable starts a conversion on channel three
    // channel three needs its latch bit cleared before the disable drops
    wr(IDX_P6_LATCH, 8'h07, 4'hF, RESP_OKAY);
    rd(IDX_P6_LATCH, 1'h0, 8'h07, RESP_OKAY);
    `CHK(conv_seen, 1'h0)
    wr(IDX_ANALOG_CTRL, 8'h03, 4'hF, RESP_OKAY);
    `CHK(conv_seen, 1'h1)
    `CHK(chan, 3'h3)
    `CHK(dis, 1'h0)
    // unmapped index answers with an error both ways
    rd(13'h0005, 1'h0, 8'h00, RESP_SLVERR);
    wr(13'h0005, 8'hFF, 4'hF, RESP_SLVERR);
    // second reset in mid-run restores the latches
    @(posedge clk);
    nrst <= 1'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    rd(IDX_P2_LATCH, 1'h1, 8'h07, RESP_OKAY);
    rd(IDX_P3_DRAIN_SELECT, 1'h0, 8'h00, RESP_OKAY);
    `CHK(dis, 1'h1)
    test_done();
  end
endmodule
`default_nettype wire
